// ==== verilog/sem_params.svh ====
// Purpose: Offsets, field positions, reset values and timing for the motion I/O block
// Assumes: 200 MHz system clock
// Notes: Register offsets are byte addresses on the plain register port
`ifndef SEM_PARAMS_SVH
`define SEM_PARAMS_SVH

`define SEM_A_CTRL 8'h00
`define SEM_A_PERIOD 8'h04
`define SEM_A_MOVE 8'h08
`define SEM_A_LIMCFG 8'h0C
`define SEM_A_ENCCFG 8'h10
`define SEM_A_POS0 8'h14
`define SEM_A_POS1 8'h18
`define SEM_A_IDXPOS 8'h1C
`define SEM_A_STATUS 8'h20
`define SEM_A_SERVO 8'h24
`define SEM_A_TORQUE 8'h28
`define SEM_A_OFFSET 8'h2C

`define SEM_B_DUAL 0
`define SEM_B_STEP_HI 1
`define SEM_B_DIFF 2
`define SEM_B_DEN_EN 3
`define SEM_B_DEN_HI 4
`define SEM_B_STOP_FIN 5
`define SEM_B_ARM 7
`define SEM_B_MOVE_REV 31
`define SEM_B_ST_FAULT 1
`define SEM_B_ST_FOUND 2
`define SEM_B_ST_LIMSTOP 7

`define SEM_RST_CTRL 6'h12
`define SEM_RST_PERIOD 16'h0064
`define SEM_RST_LIMDIV 16'h0064
`define SEM_RST_LIMPOL 3'h7
`define SEM_RST_ENCPOL 5'h1F
`define SEM_RST_VMAX 12'h7D0
`define SEM_RST_TQ_LO 16'h8000
`define SEM_RST_TQ_HI 16'h7FFF

`define SEM_CLK_MHZ 200
`define SEM_DEN_MIN_US 100
`define SEM_ENC_MIN_NS 100
`define SEM_ENC_FILT_MAX (`SEM_ENC_MIN_NS * `SEM_CLK_MHZ / 1000 - 1)
`define SEM_LIM_SAMPLES 5'h04

`endif

// ==== verilog/sem_pkg.sv ====
// Purpose: Types shared by the motion I/O block
// Assumes: Constants come from sem_params.svh
// Notes: The whole top-level state is one packed struct
package sem_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ACTIVE = 2'h1,
		ST_GAP = 2'h3
	} sem_step_state_t;

	typedef struct packed {
		logic [5:0] ctrl;
		logic [15:0] period;
		logic [2:0] lim_en;
		logic [2:0] lim_pol;
		logic [15:0] lim_div;
		logic [15:0] lim_cnt;
		logic lim_tick;
		logic [2:0] lim_prev;
		logic [4:0] enc_pol;
		logic [1:0] qual;
		logic armed;
		logic [11:0] vmax;
		logic [4:0] enc_len;
		logic [1:0] ph0_prev;
		logic [1:0] ph1_prev;
		logic idx_prev;
		logic [31:0] pos0;
		logic [31:0] pos1;
		logic [31:0] idx_pos;
		logic found;
		logic fault;
		logic limstop;
		sem_step_state_t st;
		logic [15:0] rem;
		logic [15:0] tmr;
		logic rev;
		logic den_pin;
		logic [23:0] den_tmr;
		logic cmd0_p;
		logic cmd0_n;
		logic cmd1_p;
		logic cmd1_n;
		logic [15:0] servo_cmd;
		logic [15:0] tq_lo;
		logic [15:0] tq_hi;
		logic [15:0] offset;
		logic [15:0] dac;
		logic [31:0] rdata;
	} sem_state_t;

endpackage

// ==== verilog/sem_filt_if.sv ====
// Purpose: Carrier between the motion I/O top and its glitch filter
// Assumes: One clock domain
// Notes: len is the count of agreeing samples needed to accept a level
`timescale 1ns/10ps
interface sem_filt_if #(parameter int W = 3);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	logic tick;
	logic [4:0] len;
	modport filt (input raw, input tick, input len, output clean);
	modport user (output raw, output tick, output len, input clean);
endinterface

// ==== verilog/sem_glitch_filter.sv ====
// Purpose: Bank of digital glitch filters
// Assumes: Inputs synchronous to sys_clk
// Notes: A new level passes only after len sampled ticks without a bounce
`timescale 1ns/10ps
module sem_glitch_filter #(parameter int W = 3) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Filtered lines
	sem_filt_if.filt f
);

	typedef struct packed {
		logic [W-1:0][4:0] cnt;
		logic [W-1:0] clean;
	} sem_filt_state_t;

	sem_filt_state_t s;
	sem_filt_state_t next_s;

	always_comb begin
		next_s = s;
		for (int i = 0; i < W; i++) begin
			if (f.raw[i] == s.clean[i]) begin
				next_s.cnt[i] = 5'h00;
			end else if (f.tick) begin
				// Length zero behaves as one, so a line can never freeze
				if (s.cnt[i] + 5'h01 >= f.len) begin
					next_s.clean[i] = f.raw[i];
					next_s.cnt[i] = 5'h00;
				end else begin
					next_s.cnt[i] = s.cnt[i] + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign f.clean = s.clean;

endmodule

// ==== verilog/sem_motion_io.sv ====
// Purpose: Stepper command, drive enable, servo value, limit/home and encoder logic for one axis
// Assumes: All pins synchronous to sys_clk; registers reached over a plain strobe port
// Notes: Read data appears in the cycle after the read strobe and only there
//
// How it works
// - One pulse per commanded step
// - Direction output shows commanded direction
// - Forward drives the active level, reverse opposite
// - Dual mode: forward or reverse pulse line
// - Software polarity for both stepper outputs
// - Differential mode: negative line is complement
// - Servo value clamped to limits, offset added
// - Drive enable drops at once on fault
// - Software enables drive enable, picks active level
// - Enabled limit or home edge stops motion
// - Held limit blocks, released limit allows moves
// - Limit and home inputs glitch filtered, programmable
// - Per-input enable and active level
// - Encoder filter derived from maximum velocity
// - Quadrature phases drive signed 32-bit counter
// - Leading phase picks count direction
// - Every edge of both phases counts
// - Primary channel has index, secondary none
// - Armed search latches count at index
// - Index qualified by chosen phase levels
// - Per-input encoder polarity including index
// - Accepts 100 ns encoder pulses
// - Drive enable pulses last 100 us minimum, except that a fault drop ends one at once
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "sem_params.svh"
module sem_motion_io #(parameter int DEN_MIN_CYC = `SEM_DEN_MIN_US * `SEM_CLK_MHZ) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Stepper command lines: step or forward_pulse_out, direction or reverse_pulse_out
	output logic cmd0_p,
	output logic cmd0_n,
	output logic cmd1_p,
	output logic cmd1_n,
	// Drive
	output logic [15:0] servo_dac,
	output logic drive_en_out,
	input wire logic drive_fault,
	// Switches
	input wire logic fwd_limit_in,
	input wire logic rev_limit_in,
	input wire logic home_in,
	// Encoders
	input wire logic enc0_a,
	input wire logic enc0_b,
	input wire logic enc0_idx,
	input wire logic enc1_a,
	input wire logic enc1_b
);

	sem_pkg::sem_state_t s;
	sem_pkg::sem_state_t next_s;

	sem_filt_if #(.W(3)) lim_if();
	sem_filt_if #(.W(5)) enc_if();

	sem_glitch_filter #(.W(3)) u_lim_filt (
		.sys_clk(sys_clk),
		.rst(rst),
		.f(lim_if.filt)
	);

	sem_glitch_filter #(.W(5)) u_enc_filt (
		.sys_clk(sys_clk),
		.rst(rst),
		.f(enc_if.filt)
	);

	// Quadrature step from {A,B} history; a jump of both phases is dropped
	function automatic logic [31:0] qdec(input logic [1:0] prev, input logic [1:0] cur);
		case ({prev, cur})
			4'h2, 4'hB, 4'hD, 4'h4: qdec = 32'h0000_0001;
			4'h1, 4'h7, 4'hE, 4'h8: qdec = 32'hFFFF_FFFF;
			default: qdec = 32'h0000_0000;
		endcase
	endfunction

	// Shorter filter for faster encoders, capped below the shortest legal pulse
	function automatic logic [4:0] enc_len(input logic [11:0] vmax);
		if (vmax >= 12'h3E8) begin
			enc_len = 5'h04;
		end else if (vmax >= 12'h190) begin
			enc_len = 5'h08;
		end else if (vmax >= 12'h0C8) begin
			enc_len = 5'h0C;
		end else begin
			enc_len = 5'(`SEM_ENC_FILT_MAX);
		end
	endfunction

	function automatic logic [15:0] sat16(input logic signed [17:0] v);
		if (v > 18'sh07FFF) begin
			sat16 = 16'h7FFF;
		end else if (v < -18'sh08000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	// Filter inputs
	assign lim_if.raw = {home_in, rev_limit_in, fwd_limit_in};
	assign lim_if.tick = s.lim_tick;
	assign lim_if.len = `SEM_LIM_SAMPLES;
	// Only the primary channel carries an index
	assign enc_if.raw = {enc1_b, enc1_a, enc0_idx, enc0_b, enc0_a};
	assign enc_if.tick = 1'b1;
	assign enc_if.len = s.enc_len;

	always_comb begin
		logic [2:0] lim_act;
		logic [2:0] lim_rise;
		logic [4:0] enc_lv;
		logic [1:0] ph0;
		logic [1:0] ph1;
		logic moving;
		logic stop;
		logic start;
		logic blocked;
		logic pulse;
		logic lvl0;
		logic lvl1;
		logic want_on;
		logic den_tgt;
		logic signed [15:0] clamped;
		lim_act = '0;
		lim_rise = '0;
		enc_lv = '0;
		ph0 = '0;
		ph1 = '0;
		moving = 1'b0;
		stop = 1'b0;
		start = 1'b0;
		blocked = 1'b0;
		pulse = 1'b0;
		lvl0 = 1'b0;
		lvl1 = 1'b0;
		want_on = 1'b0;
		den_tgt = 1'b0;
		clamped = '0;
		next_s = s;
		next_s.rdata = 32'h0000_0000;

		// Limit filter sample rate sets its cutoff
		next_s.lim_tick = (s.lim_cnt >= s.lim_div);
		next_s.lim_cnt = next_s.lim_tick ? 16'h0000 : s.lim_cnt + 16'h0001;
		lim_act = (lim_if.clean ^ ~s.lim_pol) & s.lim_en;
		lim_rise = lim_act & ~s.lim_prev;
		next_s.lim_prev = lim_act;

		// Encoder levels after polarity
		next_s.enc_len = enc_len(s.vmax);
		enc_lv = enc_if.clean ^ ~s.enc_pol;
		ph0 = {enc_lv[0], enc_lv[1]};
		ph1 = {enc_lv[3], enc_lv[4]};
		// Every edge of either phase is one count; sum wraps naturally
		next_s.pos0 = s.pos0 + qdec(s.ph0_prev, ph0);
		next_s.pos1 = s.pos1 + qdec(s.ph1_prev, ph1);
		next_s.ph0_prev = ph0;
		next_s.ph1_prev = ph1;
		next_s.idx_prev = enc_lv[2];

		// Step generator
		moving = (s.st != sem_pkg::ST_IDLE);
		stop = moving && ((|lim_rise) || (!s.rev && lim_act[0]) || (s.rev && lim_act[1]) || s.fault);
		case (s.st)
			sem_pkg::ST_IDLE: begin
				next_s.rem = 16'h0000;
			end
			sem_pkg::ST_ACTIVE: begin
				if (s.tmr <= 16'h0001) begin
					next_s.st = sem_pkg::ST_GAP;
					next_s.tmr = s.period;
				end else begin
					next_s.tmr = s.tmr - 16'h0001;
				end
			end
			sem_pkg::ST_GAP: begin
				if (s.tmr > 16'h0001) begin
					next_s.tmr = s.tmr - 16'h0001;
				end else if (s.rem <= 16'h0001) begin
					next_s.st = sem_pkg::ST_IDLE;
					next_s.rem = 16'h0000;
				end else begin
					next_s.st = sem_pkg::ST_ACTIVE;
					next_s.rem = s.rem - 16'h0001;
					next_s.tmr = s.period;
				end
			end
			default: begin
				next_s.st = sem_pkg::ST_IDLE;
			end
		endcase
		if (stop) begin
			// Finishing mode lets the current pulse end cleanly
			if (s.ctrl[`SEM_B_STOP_FIN]) begin
				next_s.rem = 16'h0001;
			end else begin
				next_s.st = sem_pkg::ST_IDLE;
				next_s.rem = 16'h0000;
			end
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`SEM_A_CTRL: next_s.ctrl = reg_wdata[5:0];
				`SEM_A_PERIOD: next_s.period = reg_wdata[15:0];
				`SEM_A_MOVE: begin
					// A move while moving is ignored; a held limit refuses it
					blocked = reg_wdata[`SEM_B_MOVE_REV] ? lim_act[1] : lim_act[0];
					start = !moving && (reg_wdata[15:0] != 16'h0000) && !blocked && !s.fault;
					if (start) begin
						next_s.st = sem_pkg::ST_ACTIVE;
						next_s.rem = reg_wdata[15:0];
						next_s.tmr = s.period;
						next_s.rev = reg_wdata[`SEM_B_MOVE_REV];
					end
				end
				`SEM_A_LIMCFG: begin
					next_s.lim_en = reg_wdata[2:0];
					next_s.lim_pol = reg_wdata[6:4];
					next_s.lim_div = reg_wdata[31:16];
				end
				`SEM_A_ENCCFG: begin
					next_s.enc_pol = reg_wdata[4:0];
					next_s.qual = reg_wdata[6:5];
					next_s.vmax = reg_wdata[27:16];
					if (reg_wdata[`SEM_B_ARM]) begin
						next_s.armed = 1'b1;
						next_s.found = 1'b0;
					end
				end
				`SEM_A_POS0: next_s.pos0 = reg_wdata;
				`SEM_A_POS1: next_s.pos1 = reg_wdata;
				`SEM_A_STATUS: begin
					if (reg_wdata[`SEM_B_ST_FAULT]) next_s.fault = 1'b0;
					if (reg_wdata[`SEM_B_ST_FOUND]) next_s.found = 1'b0;
					if (reg_wdata[`SEM_B_ST_LIMSTOP]) next_s.limstop = 1'b0;
				end
				`SEM_A_SERVO: next_s.servo_cmd = reg_wdata[15:0];
				`SEM_A_TORQUE: begin
					next_s.tq_lo = reg_wdata[15:0];
					next_s.tq_hi = reg_wdata[31:16];
				end
				`SEM_A_OFFSET: next_s.offset = reg_wdata[15:0];
				default: ;
			endcase
		end

		// Hardware sets come after software clears so they win
		if (drive_fault) begin
			next_s.fault = 1'b1;
		end
		if (stop || (reg_wr && reg_addr == `SEM_A_MOVE && blocked)) begin
			next_s.limstop = 1'b1;
		end
		if (s.armed && enc_lv[2] && !s.idx_prev && ph0 == s.qual) begin
			next_s.idx_pos = s.pos0;
			next_s.found = 1'b1;
			next_s.armed = 1'b0;
		end

		// Stepper pins
		pulse = (s.st == sem_pkg::ST_ACTIVE);
		if (s.ctrl[`SEM_B_DUAL]) begin
			lvl0 = pulse && !s.rev;
			lvl1 = pulse && s.rev;
		end else begin
			lvl0 = pulse;
			lvl1 = !s.rev;
		end
		next_s.cmd0_p = lvl0 ^ ~s.ctrl[`SEM_B_STEP_HI];
		next_s.cmd1_p = lvl1 ^ ~s.ctrl[`SEM_B_STEP_HI];
		next_s.cmd0_n = s.ctrl[`SEM_B_DIFF] & ~next_s.cmd0_p;
		next_s.cmd1_n = s.ctrl[`SEM_B_DIFF] & ~next_s.cmd1_p;

		// Drive enable; any pin level holds a minimum time except a fault drop
		want_on = s.ctrl[`SEM_B_DEN_EN] && !s.fault && !drive_fault;
		den_tgt = want_on ? s.ctrl[`SEM_B_DEN_HI] : ~s.ctrl[`SEM_B_DEN_HI];
		if (s.den_tmr != 24'h000000) begin
			next_s.den_tmr = s.den_tmr - 24'h000001;
		end
		if (den_tgt != s.den_pin) begin
			if (s.den_tmr == 24'h000000 || drive_fault || s.fault) begin
				next_s.den_pin = den_tgt;
				next_s.den_tmr = 24'(DEN_MIN_CYC - 1);
			end
		end

		// Servo value: clamp to torque window, then offset with saturation
		clamped = $signed(s.servo_cmd);
		if (clamped > $signed(s.tq_hi)) begin
			clamped = $signed(s.tq_hi);
		end
		if (clamped < $signed(s.tq_lo)) begin
			clamped = $signed(s.tq_lo);
		end
		next_s.dac = sat16(18'(clamped) + 18'($signed(s.offset)));

		// Register reads
		if (reg_rd) begin
			case (reg_addr)
				`SEM_A_CTRL: next_s.rdata = {26'h0, s.ctrl};
				`SEM_A_PERIOD: next_s.rdata = {16'h0, s.period};
				`SEM_A_MOVE: next_s.rdata = {s.rev, 15'h0, s.rem};
				`SEM_A_LIMCFG: next_s.rdata = {s.lim_div, 9'h0, s.lim_pol, 1'b0, s.lim_en};
				`SEM_A_ENCCFG: next_s.rdata = {4'h0, s.vmax, 8'h0, s.armed, s.qual, s.enc_pol};
				`SEM_A_POS0: next_s.rdata = s.pos0;
				`SEM_A_POS1: next_s.rdata = s.pos1;
				`SEM_A_IDXPOS: next_s.rdata = s.idx_pos;
				`SEM_A_STATUS: next_s.rdata = {s.rem, 8'h0, s.limstop, lim_act, s.den_pin, s.found, s.fault, moving};
				`SEM_A_SERVO: next_s.rdata = {16'h0, s.servo_cmd};
				`SEM_A_TORQUE: next_s.rdata = {s.tq_hi, s.tq_lo};
				`SEM_A_OFFSET: next_s.rdata = {16'h0, s.offset};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			// Enable inactive, step line idle, counters zero
			s <= '0;
			s.ctrl <= `SEM_RST_CTRL;
			s.period <= `SEM_RST_PERIOD;
			s.lim_pol <= `SEM_RST_LIMPOL;
			s.lim_div <= `SEM_RST_LIMDIV;
			s.enc_pol <= `SEM_RST_ENCPOL;
			s.vmax <= `SEM_RST_VMAX;
			s.enc_len <= 5'h04;
			s.tq_lo <= `SEM_RST_TQ_LO;
			s.tq_hi <= `SEM_RST_TQ_HI;
			s.cmd0_p <= 1'b0;
			s.cmd1_p <= 1'b0;
			s.st <= sem_pkg::ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign cmd0_p = s.cmd0_p;
	assign cmd0_n = s.cmd0_n;
	assign cmd1_p = s.cmd1_p;
	assign cmd1_n = s.cmd1_n;
	assign servo_dac = s.dac;
	assign drive_en_out = s.den_pin;

endmodule

// ==== verification/sem_motion_io_props.sv ====
// Purpose: Port checks for the motion I/O block
// Assumes: Bound into sem_motion_io, one clock
// Notes: held counts cycles since drive enable last moved
`timescale 1ns/10ps
module sem_motion_io_chk #(parameter int DEN_MIN_CYC = 20) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Pins
	input wire logic cmd0_p,
	input wire logic cmd0_n,
	input wire logic cmd1_p,
	input wire logic cmd1_n,
	input wire logic [15:0] servo_dac,
	input wire logic drive_en_out,
	input wire logic drive_fault
);
	logic [31:0] held;
	// Saturates so a long quiet spell never wraps
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			held <= 32'(DEN_MIN_CYC);
		else if ($changed(drive_en_out))
			held <= 32'h1;
		else if (held < 32'(DEN_MIN_CYC))
			held <= held + 32'h1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_diff_step: assert property (cmd0_n |-> !cmd0_p)
		else $error("step pair not complementary");
	a_diff_dir: assert property (cmd1_n |-> !cmd1_p)
		else $error("direction pair not complementary");
	a_diff_both: assert property (cmd0_n || cmd1_n |-> (cmd0_n ^ cmd0_p) && (cmd1_n ^ cmd1_p))
		else $error("differential mode on one pair only");
	a_fault_off: assert property (drive_fault [*2] |=> $stable(drive_en_out))
		else $error("drive enable moved during fault");
	a_enable_hold: assert property ($changed(drive_en_out) && !drive_fault && !$past(drive_fault) |-> held >= 32'(DEN_MIN_CYC))
		else $error("drive enable level too short");
	a_reset_quiet: assert property (disable iff (1'b0) rst |-> !drive_en_out && !cmd0_p && !cmd0_n && !cmd1_p && !cmd1_n)
		else $error("output active in reset");
	a_servo_still: assert property (!$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3) |-> $stable(servo_dac))
		else $error("servo value moved without a write");
	c_step: cover property ($rose(cmd0_p));
	c_fault: cover property ($rose(drive_fault) ##2 !drive_en_out);
	c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind sem_motion_io sem_motion_io_chk #(.DEN_MIN_CYC(DEN_MIN_CYC)) chk (.sys_clk(sys_clk), .rst(rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd0_p(cmd0_p), .cmd0_n(cmd0_n),
	.cmd1_p(cmd1_p), .cmd1_n(cmd1_n), .servo_dac(servo_dac), .drive_en_out(drive_en_out),
	.drive_fault(drive_fault));

// ==== verification/sem_far_side.sv ====
// Purpose: Drive pulse counter, switches, fault and encoders of one axis
// Assumes: Levels change just after a rising clock edge
// Notes: Quadrature edges are 105 ns apart, just over the 100 ns shortest pulse allowed; index pulses last exactly 100 ns
`timescale 1ns/10ps
module sem_far_side (
	// Clock and stepper lines
	input wire logic sys_clk,
	input wire logic cmd0_p,
	input wire logic cmd1_p,
	// Switches and fault
	output logic fwd_limit_in,
	output logic rev_limit_in,
	output logic home_in,
	output logic drive_fault,
	// Encoders
	output logic enc0_a,
	output logic enc0_b,
	output logic enc0_idx,
	output logic enc1_a,
	output logic enc1_b
);
	int fwd_n = 0;
	int rev_n = 0;
	initial {fwd_limit_in, rev_limit_in, home_in, drive_fault, enc0_a, enc0_b, enc0_idx, enc1_a, enc1_b} = 9'h000;
	always @(posedge cmd0_p) fwd_n++;
	always @(posedge cmd1_p) rev_n++;
	// Levels stay until changed, so a held limit keeps blocking
	task automatic sw(input logic f, input logic r, input logic h);
		@(posedge sys_clk);
		{fwd_limit_in, rev_limit_in, home_in} <= {f, r, h};
	endtask
	task automatic fault(input logic v);
		@(posedge sys_clk);
		drive_fault <= v;
	endtask
	// Forward: phase A leads phase B by a quarter cycle
	task automatic quad(input logic ch, input logic up, input int n);
		logic [1:0] s;
		repeat (n) begin
			s = ch ? {enc1_a, enc1_b} : {enc0_a, enc0_b};
			s = up ? {~s[0], s[1]} : {s[0], ~s[1]};
			@(posedge sys_clk);
			if (ch)
				{enc1_a, enc1_b} <= s;
			else
				{enc0_a, enc0_b} <= s;
			repeat (20) @(posedge sys_clk);
		end
	endtask
	task automatic jump;
		@(posedge sys_clk);
		{enc0_a, enc0_b} <= ~{enc0_a, enc0_b};
		repeat (20) @(posedge sys_clk);
	endtask
	task automatic idx_pulse;
		@(posedge sys_clk);
		enc0_idx <= 1'b1;
		repeat (20) @(posedge sys_clk);
		enc0_idx <= 1'b0;
		repeat (20) @(posedge sys_clk);
	endtask
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the motion I/O block
// Assumes: sem_far_side plays drive, switches and encoders
// Notes: Drive enable hold shortened to 20 cycles
`timescale 1ns/10ps
`include "sem_params.svh"
module tb_top;
	logic sys_clk = 1'b0;
	logic rst;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, rv, b0;
	logic [15:0] servo_dac;
	logic cmd0_p, cmd0_n, cmd1_p, cmd1_n, drive_en_out, drive_fault, fwd_limit_in, rev_limit_in, home_in;
	logic enc0_a, enc0_b, enc0_idx, enc1_a, enc1_b;
	int num_errors = 0;
	int tests_run = 0;
	initial forever #2.5 sys_clk = ~sys_clk;
	sem_motion_io #(.DEN_MIN_CYC(20)) dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd0_p(cmd0_p),
		.cmd0_n(cmd0_n), .cmd1_p(cmd1_p), .cmd1_n(cmd1_n), .servo_dac(servo_dac), .drive_en_out(drive_en_out),
		.drive_fault(drive_fault), .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in), .home_in(home_in),
		.enc0_a(enc0_a), .enc0_b(enc0_b), .enc0_idx(enc0_idx), .enc1_a(enc1_a), .enc1_b(enc1_b));
	sem_far_side far (.sys_clk(sys_clk), .cmd0_p(cmd0_p), .cmd1_p(cmd1_p), .fwd_limit_in(fwd_limit_in),
		.rev_limit_in(rev_limit_in), .home_in(home_in), .drive_fault(drive_fault), .enc0_a(enc0_a),
		.enc0_b(enc0_b), .enc0_idx(enc0_idx), .enc1_a(enc1_a), .enc1_b(enc1_b));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		rd(a);
		chk(n, rv, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Bounded poll so a stuck move cannot hang the run
	task automatic idle;
		int i;
		rd(`SEM_A_STATUS);
		for (i = 0; i < 400 && rv[0] !== 1'b0; i++)
			rd(`SEM_A_STATUS);
		chk("move end", rv[0], 1'b0);
	endtask
	task automatic go(input logic dir, input logic [15:0] n);
		far.fwd_n = 0;
		far.rev_n = 0;
		wr(`SEM_A_MOVE, {dir, 15'h0, n});
	endtask
	task automatic fin(input int f, input int r);
		idle();
		chk("fwd pulses", far.fwd_n, f);
		chk("rev pulses", far.rev_n, r);
	endtask
	task automatic t_reset;
		rdc(`SEM_A_CTRL, 32'h12, "ctrl");
		rdc(`SEM_A_PERIOD, 32'h64, "period");
		rdc(`SEM_A_LIMCFG, 32'h00640070, "limcfg");
		rdc(`SEM_A_ENCCFG, 32'h07D0001F, "enccfg");
		rdc(`SEM_A_TORQUE, 32'h7FFF8000, "torque");
		rdc(`SEM_A_POS0, 32'h0, "pos0");
		rdc(`SEM_A_STATUS, 32'h0, "status");
		wr(8'hFC, 32'hFFFFFFFF);
		rdc(8'hFC, 32'h0, "unmapped");
		chk("enable", drive_en_out, 1'b0);
		chk("dir", cmd1_p, 1'b1);
		$display("reset test done");
	endtask
	task automatic t_step;
		wr(`SEM_A_PERIOD, 32'h2);
		go(1'b0, 16'h3);
		fin(3, 0);
		go(1'b1, 16'h2);
		fin(2, 0);
		chk("dir rev", cmd1_p, 1'b0);
		wr(`SEM_A_CTRL, 32'h10);
		cyc(3);
		chk("step low", cmd0_p, 1'b1);
		chk("dir low", cmd1_p, 1'b1);
		wr(`SEM_A_CTRL, 32'h17);
		cyc(3);
		chk("step n", cmd0_n, 1'b1);
		chk("dir n", cmd1_n, 1'b1);
		go(1'b0, 16'h2);
		fin(2, 0);
		go(1'b1, 16'h2);
		fin(0, 2);
		$display("step test done");
	endtask
	task automatic t_limit;
		wr(`SEM_A_LIMCFG, 32'h00010071);
		far.sw(1'b1, 1'b1, 1'b0);
		cyc(20);
		go(1'b0, 16'h3);
		fin(0, 0);
		rd(`SEM_A_STATUS);
		chk("limit stop", rv[7], 1'b1);
		go(1'b1, 16'h2);
		fin(0, 2);
		far.sw(1'b0, 1'b0, 1'b0);
		wr(`SEM_A_STATUS, 32'h80);
		cyc(20);
		go(1'b0, 16'd20);
		far.sw(1'b1, 1'b0, 1'b0);
		far.sw(1'b0, 1'b0, 1'b0);
		fin(20, 0);
		go(1'b0, 16'd40);
		cyc(10);
		far.sw(1'b1, 1'b0, 1'b0);
		cyc(20);
		far.sw(1'b0, 1'b0, 1'b0);
		idle();
		chk("cut short", far.fwd_n < 40, 1'b1);
		cyc(20);
		go(1'b0, 16'h2);
		fin(2, 0);
		// Finishing stop: the pulse in flight runs its full length
		wr(`SEM_A_CTRL, 32'h37);
		wr(`SEM_A_PERIOD, 32'h40);
		go(1'b0, 16'h2);
		far.sw(1'b1, 1'b0, 1'b0);
		cyc(20);
		chk("pulse kept", cmd0_p, 1'b1);
		fin(1, 0);
		far.sw(1'b0, 1'b0, 1'b0);
		cyc(20);
		$display("limit test done");
	endtask
	task automatic t_enc;
		far.quad(1'b0, 1'b1, 8);
		rdc(`SEM_A_POS0, 32'h8, "pos up");
		far.quad(1'b0, 1'b0, 3);
		rdc(`SEM_A_POS0, 32'h5, "pos down");
		far.jump();
		far.jump();
		rdc(`SEM_A_POS0, 32'h5, "pos jump");
		wr(`SEM_A_POS0, 32'hFFFFFFFF);
		far.quad(1'b0, 1'b1, 1);
		rdc(`SEM_A_POS0, 32'h0, "pos wrap");
		// Bit 6 is the required A level and bit 5 the required B level
		wr(`SEM_A_ENCCFG, 32'h07D000DF);
		far.idx_pulse();
		rd(`SEM_A_STATUS);
		chk("no found", rv[2], 1'b0);
		far.quad(1'b0, 1'b0, 1);
		far.idx_pulse();
		rdc(`SEM_A_IDXPOS, 32'hFFFFFFFF, "idxpos");
		rd(`SEM_A_STATUS);
		chk("found", rv[2], 1'b1);
		far.quad(1'b1, 1'b1, 4);
		rdc(`SEM_A_POS1, 32'h4, "pos1");
		wr(`SEM_A_ENCCFG, 32'h07D00017);
		cyc(20);
		rd(`SEM_A_POS1);
		b0 = rv;
		far.quad(1'b1, 1'b1, 2);
		rdc(`SEM_A_POS1, b0 - 32'h2, "pos1 inv");
		$display("encoder test done");
	endtask
	task automatic t_drive;
		wr(`SEM_A_TORQUE, 32'h1000F000);
		wr(`SEM_A_OFFSET, 32'h10);
		wr(`SEM_A_SERVO, 32'h7000);
		cyc(3);
		chk("servo hi", servo_dac, 16'h1010);
		wr(`SEM_A_SERVO, 32'h8000);
		cyc(3);
		chk("servo lo", servo_dac, 16'hF010);
		wr(`SEM_A_CTRL, 32'h1A);
		cyc(3);
		chk("en on", drive_en_out, 1'b1);
		wr(`SEM_A_CTRL, 32'h12);
		cyc(5);
		chk("en held", drive_en_out, 1'b1);
		cyc(20);
		chk("en off", drive_en_out, 1'b0);
		wr(`SEM_A_CTRL, 32'h1A);
		cyc(25);
		far.fault(1'b1);
		cyc(2);
		chk("fault drop", drive_en_out, 1'b0);
		far.fault(1'b0);
		cyc(25);
		chk("fault kept", drive_en_out, 1'b0);
		wr(`SEM_A_STATUS, 32'h2);
		cyc(25);
		chk("en back", drive_en_out, 1'b1);
		wr(`SEM_A_CTRL, 32'h0A);
		cyc(25);
		chk("en low on", drive_en_out, 1'b0);
		$display("drive test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		$display("watchdog expired");
		test_done();
	end
	initial begin
		// Scheduled so the asynchronous reset sees a real rising edge at start
		rst <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_step();
		t_limit();
		t_enc();
		t_drive();
		test_done();
	end
endmodule
